// *** rtl/bti2c_pkg.sv ***
// Purpose: shared constants for the barometer two-wire target port
// Assumes: 100 MHz system clock, 7-bit addressing
// Notes: address upper bits fixed, lowest bit strapped
package bti2c_pkg;
    localparam logic [5:0] ADDR_HIGH = 6'h36; // 110110
    localparam int ADDR_BITS = 7;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int REG_ADDR_W = 8;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK,
        ST_WDATA,
        ST_RDATA,
        ST_RACK,
        ST_IGNORE
    } bti2c_state_t;
endpackage : bti2c_pkg

// *** rtl/bti2c_target.sv ***
// Purpose: two-wire target port of a digital barometer
// Assumes: scl and sda arrive asynchronously and are synchronised here
// Notes: register storage lives outside; this port offers a byte strobe
`timescale 1ns/1ps
`default_nettype none
module bti2c_target
    import bti2c_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic addr_sel_in,
    input wire logic serial_sel_in,
    input wire logic conv_done_in,
    input wire logic conv_done_clr,
    output logic int_out,
    output logic twowire_mode,
    output logic [bti2c_pkg::REG_ADDR_W-1:0] reg_addr,
    output logic [7:0] wr_data,
    output logic wr_strobe,
    output logic rd_strobe,
    input wire logic [7:0] rd_data
);
    import bti2c_pkg::*;

    // two-stage synchronisers for the scl, sda, address-select and serial-select pins
    logic [1:0] scl_s_r, sda_s_r, asel_s_r, ssel_s_r;
    logic scl_d_r, sda_d_r;
    always_ff @(posedge clk_sys) begin
        scl_s_r <= {scl_s_r[0], scl_in};
        sda_s_r <= {sda_s_r[0], sda_in};
        asel_s_r <= {asel_s_r[0], addr_sel_in};
        ssel_s_r <= {ssel_s_r[0], serial_sel_in};
        scl_d_r <= scl_s_r[1];
        sda_d_r <= sda_s_r[1];
    end

    wire scl = scl_s_r[1];
    wire sda = sda_s_r[1];
    wire scl_rise = scl & ~scl_d_r;
    wire scl_fall = ~scl & scl_d_r;
    wire start_ev = scl & scl_d_r & sda_d_r & ~sda;
    wire stop_ev = scl & scl_d_r & ~sda_d_r & sda;
    // serial-select low forces the state machine to idle, so it also gates every transfer
    wire two_wire = ssel_s_r[1];
    wire [6:0] own_addr = {ADDR_HIGH, asel_s_r[1]};

    bti2c_state_t state_r, state_nxt;
    logic [2:0] bit_r;
    logic armed_r;
    logic [7:0] shift_r;
    logic rw_r, have_ptr_r, drive_low_r, int_r, mode_r;
    logic [REG_ADDR_W-1:0] ptr_r;
    logic [7:0] wdat_r;
    logic wstb_r, rstb_r, acked_r;

    // decode of the received address byte
    wire addr_match = (shift_r[7:1] == own_addr);
    wire byte_done = scl_fall & (bit_r == BIT_LAST);
    wire [7:0] shift_in = {shift_r[6:0], sda};

    // next state; start, stop and serial-select low act at once, other steps on scl falling edges
    always_comb begin
        state_nxt = state_r;
        if (!two_wire) begin
            state_nxt = ST_IDLE;
        end else if (start_ev) begin
            state_nxt = ST_ADDR;
        end else if (stop_ev) begin
            state_nxt = ST_IDLE;
        end else begin
            case (state_r)
                ST_ADDR: begin
                    if (byte_done) begin
                        state_nxt = addr_match ? ST_ACK : ST_IGNORE;
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        state_nxt = rw_r ? ST_RDATA : ST_WDATA;
                    end
                end
                ST_WDATA: begin
                    if (byte_done) begin
                        state_nxt = ST_ACK;
                    end
                end
                ST_RDATA: begin
                    if (byte_done) begin
                        state_nxt = ST_RACK;
                    end
                end
                ST_RACK: begin
                    // ack bit was shifted in at the rise; move on the fall
                    if (scl_fall) begin
                        state_nxt = shift_r[0] ? ST_IGNORE : ST_RDATA;
                    end
                end
                default: state_nxt = state_r;
            endcase
        end
    end

    // bit counter stepped on scl falling edge, shift register sampled on scl rising edge
    always_ff @(posedge clk_sys) begin
        if (!rst_n || start_ev || state_r == ST_ACK
                || state_r == ST_RACK) begin
            bit_r <= 3'h0;
        end else if (scl_fall && ((state_r == ST_ADDR && armed_r)
                || state_r == ST_WDATA || state_r == ST_RDATA)) begin
            bit_r <= bit_r + 3'h1;
        end
        // the fall just after a start carries no bit, so it is not counted
        if (!rst_n || start_ev) begin
            armed_r <= 1'b0;
        end else if (scl_rise) begin
            armed_r <= 1'b1;
        end
        if (!rst_n) begin
            shift_r <= 8'h00;
        end else if (scl_rise) begin
            shift_r <= shift_in;
        end
    end

    // transfer bookkeeping
    always_ff @(posedge clk_sys) begin
        wstb_r <= 1'b0;
        rstb_r <= 1'b0;
        if (!rst_n) begin
            state_r <= ST_IDLE;
            rw_r <= 1'b0;
            have_ptr_r <= 1'b0;
            ptr_r <= REG_RESET;
            wdat_r <= 8'h00;
            acked_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (start_ev) begin
                have_ptr_r <= 1'b0;
                acked_r <= 1'b0;
            end
            if (byte_done && state_r == ST_ADDR) begin
                rw_r <= shift_r[0];
                // read starts from the current pointer
                rstb_r <= shift_r[0] & addr_match;
            end
            if (byte_done && state_r == ST_WDATA) begin
                if (!have_ptr_r) begin
                    ptr_r <= shift_r;
                    have_ptr_r <= 1'b1;
                end else begin
                    wdat_r <= shift_r;
                    wstb_r <= 1'b1;
                    acked_r <= 1'b1;
                end
            end
            // pointer steps after each stored byte and each acked read
            if (acked_r && wstb_r) begin
                ptr_r <= ptr_r + 8'h01;
            end
            if (state_r == ST_RACK && scl_rise && !sda) begin
                ptr_r <= ptr_r + 8'h01;
                rstb_r <= 1'b1;
            end
        end
    end

    // data line drive; changes only on scl low phase
    // bit to put out next: the counter steps at this same fall
    wire [2:0] rd_idx = (state_r == ST_RDATA) ? bit_r + 3'h1 : 3'h0;
    wire rd_bit = rd_data[3'h7 - rd_idx];
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            drive_low_r <= 1'b0;
        end else if (state_nxt == ST_IDLE || state_nxt == ST_IGNORE) begin
            drive_low_r <= 1'b0;
        end else if (scl_fall || (state_r != state_nxt)) begin
            // updated only once scl is seen low
            case (state_nxt)
                ST_ACK: drive_low_r <= ~scl;
                ST_RDATA: drive_low_r <= ~scl & ~rd_bit;
                default: drive_low_r <= 1'b0;
            endcase
        end
    end

    // data ready flag; a new result wins over a clear
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            int_r <= 1'b0;
            mode_r <= 1'b1;
        end else begin
            int_r <= conv_done_in | (int_r & ~conv_done_clr);
            mode_r <= two_wire;
        end
    end

    assign sda_out = 1'b0; // open drain: only ever pulls low
    assign sda_oe_n = ~drive_low_r;
    assign int_out = int_r;
    assign twowire_mode = mode_r;
    assign reg_addr = ptr_r;
    assign wr_data = wdat_r;
    assign wr_strobe = wstb_r;
    assign rd_strobe = rstb_r;

    // checks on what the port itself drives
    a_ack_low: assert property (@(posedge clk_sys)
        disable iff (!rst_n)
        (state_r == ST_ACK && !scl) |=> !sda_oe_n || state_r != ST_ACK)
        else $error("ack not driven");
    a_stop_idle: assert property (@(posedge clk_sys)
        disable iff (!rst_n)
        stop_ev && two_wire |=> ##1 sda_oe_n)
        else $error("bus held after stop");
    a_ignore_rel: assert property (@(posedge clk_sys)
        disable iff (!rst_n)
        state_r == ST_IGNORE |-> ##1 sda_oe_n)
        else $error("driving while ignored");
    a_hold_high: assert property (@(posedge clk_sys)
        disable iff (!rst_n)
        scl && scl_d_r && !start_ev && !stop_ev |=> $stable(sda_oe_n))
        else $error("data moved while clock high");
    a_start_restart: assert property (@(posedge clk_sys)
        disable iff (!rst_n)
        start_ev && two_wire |=> state_r == ST_ADDR && bit_r == 3'h0)
        else $error("start not restarting");
    a_int_set: assert property (@(posedge clk_sys)
        disable iff (!rst_n)
        conv_done_in |=> int_out)
        else $error("ready not flagged");
    a_mode_sel: assert property (@(posedge clk_sys)
        disable iff (!rst_n)
        !two_wire |=> state_r == ST_IDLE && twowire_mode == 1'b0)
        else $error("two-wire active in four-wire mode");
    a_addr_nomatch: assert property (@(posedge clk_sys)
        disable iff (!rst_n)
        state_r == ST_ADDR && byte_done && !addr_match && !stop_ev
            && !start_ev && two_wire |=> state_r == ST_IGNORE)
        else $error("foreign address accepted");
    // a whole byte that the port owes an acknowledge for
    sequence s_ack_owed;
        byte_done && two_wire && !start_ev && !stop_ev
            && (state_r == ST_WDATA || (state_r == ST_ADDR && addr_match));
    endsequence
    a_ack_owed: assert property (@(posedge clk_sys)
        disable iff (!rst_n)
        s_ack_owed |=> ##1 !sda_oe_n)
        else $error("byte not acknowledged");
    a_ptr_step: assert property (@(posedge clk_sys)
        disable iff (!rst_n)
        wr_strobe |=> reg_addr == $past(reg_addr) + 8'h01)
        else $error("pointer not stepped after write");
endmodule : bti2c_target
`default_nettype wire

// *** test/bti2c_host_model.sv ***
// Purpose: behavioural two-wire bus controller that drives the target port
// Assumes: one bit is 12 system clocks, pull-up on the data wire
// Notes: data moves mid-low phase, sampled at the end of the high phase
`timescale 1ns/1ps
`default_nettype none
module bti2c_host_model (
    input wire logic clk_sys,
    input wire logic dev_oe_n,
    input wire logic dev_out,
    output logic scl,
    output logic sda
);
    logic host_low = 1'b0;
    initial scl = 1'b1;
    // wired-and with pull-up, so an unknown enable reads as released
    // a device that drives anything but a clean low counts as released
    assign sda = (host_low || (dev_oe_n === 1'b0 && dev_out === 1'b0))
        ? 1'b0 : 1'b1;
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tick
    // data only moves while the clock is low
    task automatic put_bit(input logic b);
        scl <= 1'b0;
        tick(3);
        host_low <= ~b;
        tick(3);
        scl <= 1'b1;
        tick(6);
    endtask : put_bit
    task automatic get_bit(output logic b);
        put_bit(1'b1);
        b = sda;
    endtask : get_bit
    // start also serves as repeated start
    task automatic start();
        put_bit(1'b1);
        host_low <= 1'b1;
        tick(6);
    endtask : start
    task automatic stop();
        put_bit(1'b0);
        host_low <= 1'b0;
        tick(6);
    endtask : stop
    // msb first, acknowledge read in the ninth clock
    task automatic wbyte(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i]);
        end
        get_bit(ack);
        ack = ~ack;
    endtask : wbyte
    task automatic rbyte(input logic ack, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            get_bit(d[i]);
        end
        put_bit(~ack);
    endtask : rbyte
endmodule : bti2c_host_model
`default_nettype wire

// *** test/bti2c_target_tb.sv ***
// Purpose: self-checking bench for the two-wire target port
// Assumes: host model on the bus, rd_data answers pointer xor 5a
// Notes: bench watches device drive cycles to catch stray pulls
`timescale 1ns/1ps
`default_nettype none
module bti2c_target_tb;
    import bti2c_pkg::*;
    logic clk_sys, rst_n, addr_sel_in, serial_sel_in;
    logic conv_done_in, conv_done_clr, sda_oe_n, int_out, twowire_mode;
    logic wr_strobe, rd_strobe, scl, sda, sda_out;
    logic [7:0] reg_addr, wr_data, rd_data, wr_a, wr_d;
    int errors, tests_run, drv;
    bti2c_target i_bti2c_target (.clk_sys(clk_sys), .rst_n(rst_n),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .addr_sel_in(addr_sel_in), .serial_sel_in(serial_sel_in),
        .conv_done_in(conv_done_in), .conv_done_clr(conv_done_clr),
        .int_out(int_out), .twowire_mode(twowire_mode),
        .reg_addr(reg_addr), .wr_data(wr_data), .wr_strobe(wr_strobe),
        .rd_strobe(rd_strobe), .rd_data(rd_data));
    bti2c_host_model i_bti2c_host_model (.clk_sys(clk_sys),
        .dev_oe_n(sda_oe_n), .dev_out(sda_out), .scl(scl), .sda(sda));
    // register side stand-in: record writes, answer reads
    always @(posedge clk_sys) begin
        if (wr_strobe === 1'b1) begin
            wr_a <= reg_addr;
            wr_d <= wr_data;
        end
        if (rd_strobe === 1'b1) rd_data <= reg_addr ^ 8'h5a;
        if (sda_oe_n === 1'b0) drv++;
    end
    task automatic chk(input string n, input logic [7:0] e, g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wb(input logic [7:0] d, input logic e);
        logic a;
        i_bti2c_host_model.wbyte(d, a);
        chk("ack", {7'h00, e}, {7'h00, a});
    endtask : wb
    task automatic rb(input logic a, input logic [7:0] e);
        logic [7:0] d;
        i_bti2c_host_model.rbyte(a, d);
        chk("rd_byte", e, d);
    endtask : rb
    task automatic t_write();
        i_bti2c_host_model.start();
        wb(8'hd8, 1'b1);
        wb(8'h10, 1'b1);
        wb(8'h3c, 1'b1);
        chk("wr_addr", 8'h10, wr_a);
        chk("wr_data", 8'h3c, wr_d);
        wb(8'hc3, 1'b1);
        chk("wr_addr_inc", 8'h11, wr_a);
        i_bti2c_host_model.stop();
    endtask : t_write
    task automatic t_read();
        addr_sel_in <= 1'b1;
        i_bti2c_host_model.start();
        wb(8'hda, 1'b1);
        wb(8'h20, 1'b1);
        i_bti2c_host_model.start();
        wb(8'hdb, 1'b1);
        rb(1'b1, 8'h7a);
        rb(1'b0, 8'h7b);
        i_bti2c_host_model.stop();
    endtask : t_read
    task automatic t_ignore();
        drv = 0;
        i_bti2c_host_model.start();
        wb(8'hd8, 1'b0);
        wb(8'hda, 1'b0);
        i_bti2c_host_model.stop();
        chk("drive_cycles", 8'h00, (drv > 0) ? 8'hff : 8'h00);
    endtask : t_ignore
    task automatic t_mode();
        serial_sel_in <= 1'b0;
        i_bti2c_host_model.start();
        chk("twowire_mode", 8'h00, {7'h00, twowire_mode});
        wb(8'hda, 1'b0);
        i_bti2c_host_model.stop();
        serial_sel_in <= 1'b1;
        i_bti2c_host_model.tick(6);
        chk("twowire_mode", 8'h01, {7'h00, twowire_mode});
    endtask : t_mode
    // pulse set, clear, then both together where set must win
    task automatic t_int(input logic s, c, e);
        conv_done_in <= s;
        conv_done_clr <= c;
        @(posedge clk_sys);
        conv_done_in <= 1'b0;
        conv_done_clr <= 1'b0;
        i_bti2c_host_model.tick(4);
        chk("int_out", {7'h00, e}, {7'h00, int_out});
    endtask : t_int
    task automatic final_report();
        if (errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        {rst_n, addr_sel_in, conv_done_in, conv_done_clr} = 4'h0;
        serial_sel_in = 1'b1;
        errors = 0;
        tests_run = 0;
        drv = 0;
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        t_write();
        t_read();
        t_ignore();
        t_mode();
        t_int(1'b1, 1'b0, 1'b1);
        t_int(1'b0, 1'b1, 1'b0);
        t_int(1'b1, 1'b1, 1'b1);
        final_report();
    end
    // whole run is near 15 us; a hang is cut well after that
    initial begin
        #300000;
        errors++;
        final_report();
    end
endmodule : bti2c_target_tb
`default_nettype wire
